/* File: design/oss_strap_loader.sv */
// Option strap capture, spindle start sequencer and APB register file.
//
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/10ps

// Notes on behaviour
// R1: Capture active-low identifier during sampling window.
// R2: No start straps: spin immediately after power-up.
// R3: Command strap only: wait for Start Unit.
// R4: Delay strap only: wait identifier times twelve seconds.
// R5: Both straps: Start Unit only, no delay.
// R6: Write-protect strap protects entire storage.
// R7: Parity-off strap: no checking, no reporting.
// R8: Otherwise check parity and report result.
// R9: Force-single-ended strap selects single-ended only.
// R10: Otherwise mode follows DIFFSENS line.
// R11: Strap changes apply only after reset.
// R12: Host drives strap levels on connector variants.
// R13: Identifier seven has highest arbitration priority.
// R14: Captured straps held stable until reset.
module oss_strap_loader #(
	parameter int unsigned SAMPLE_CYC    = oss_pkg::SAMPLE_CYC,
	parameter int unsigned SPIN_STEP_CYC = oss_pkg::SPIN_STEP_CYC
) (
	// Clock and reset
	input  wire logic        CLK_SYS,
	input  wire logic        RESET,
	// Strap pins, active low
	input  wire logic [3:0]  BUS_ID_N,
	input  wire logic        DELAYED_SPIN_STRAP_N,
	input  wire logic        SPIN_ON_COMMAND_STRAP_N,
	input  wire logic        WRITE_PROT_STRAP_N,
	input  wire logic        PARITY_OFF_STRAP_N,
	input  wire logic        FORCE_SINGLE_ENDED_STRAP_N,
	// Bus mode sense pin
	input  wire logic        DIFFSENS,
	// Parity checker result, one-cycle pulse
	input  wire logic        PARITY_FAIL,
	// APB slave
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic             PREADY,
	output logic      [31:0] PRDATA,
	output logic             PSLVERR,
	// Decoded controls
	output logic      [3:0]  BUS_ID,
	output logic             ID_TOP_PRIORITY,
	output logic             CONFIG_VALID,
	output logic             SPIN_ENABLE,
	output logic             WRITE_PROTECT,
	output logic             PARITY_CHECK_EN,
	output logic             PARITY_ERR_REPORT,
	output logic             LVD_MODE,
	// Interrupt
	output logic             IRQ
);

	// ==========================================================
	// Synchronisers
	// ==========================================================
	localparam logic [9:0] SYNC_RST = 10'h3FE;

	logic [9:0] pins_s;
	logic [3:0] id_s;
	logic       ds_s;
	logic       me_s;
	logic       wp_s;
	logic       pd_s;
	logic       se_s;
	logic       diff_s;

	oss_sync #(.W(10), .RST(SYNC_RST)) u_sync (
		.clk (CLK_SYS),
		.rst (RESET),
		.d   ({BUS_ID_N, DELAYED_SPIN_STRAP_N,
		       SPIN_ON_COMMAND_STRAP_N, WRITE_PROT_STRAP_N,
		       PARITY_OFF_STRAP_N, FORCE_SINGLE_ENDED_STRAP_N,
		       DIFFSENS}),
		.q   (pins_s)
	);

	assign id_s   = ~pins_s[9:6];
	assign ds_s   = ~pins_s[5];
	assign me_s   = ~pins_s[4];
	assign wp_s   = ~pins_s[3];
	assign pd_s   = ~pins_s[2];
	assign se_s   = ~pins_s[1];
	assign diff_s = pins_s[0];

	// ==========================================================
	// Strap capture
	// ==========================================================
	oss_pkg::oss_state_e state_r;
	logic [31:0] win_cnt_r;
	logic [3:0]  id_r;
	logic        ds_r;
	logic        me_r;
	logic        wp_r;
	logic        pd_r;
	logic        se_r;
	logic        win_end;

	assign win_end = (state_r == oss_pkg::ST_SAMPLE)
		&& (win_cnt_r == SAMPLE_CYC - 1);

	always_ff @(posedge CLK_SYS or posedge RESET)
	begin
		if (RESET)
			win_cnt_r <= 32'h0000_0000;
		else if (state_r == oss_pkg::ST_SAMPLE && !win_end)
			win_cnt_r <= win_cnt_r + 32'h0000_0001;
	end

	// Straps are tracked over the whole window; the last sample wins.
	always_ff @(posedge CLK_SYS or posedge RESET)
	begin
		if (RESET)
		begin
			id_r <= 4'h0;
			ds_r <= 1'b0;
			me_r <= 1'b0;
			wp_r <= 1'b0;
			pd_r <= 1'b0;
			se_r <= 1'b0;
		end
		else if (state_r == oss_pkg::ST_SAMPLE) // R1 R11 R14
		begin
			id_r <= id_s;
			ds_r <= ds_s;
			me_r <= me_s;
			wp_r <= wp_s;
			pd_r <= pd_s;
			se_r <= se_s;
		end
	end

	// ==========================================================
	// Register file
	// ==========================================================
	logic       setup;
	logic       wr_acc;
	logic       start_cmd;
	logic [2:0] istat_r;
	logic [2:0] imask_r;
	logic [2:0] irq_evt;
	logic [2:0] w1c;

	assign setup  = PSEL && !PENABLE;
	assign wr_acc = PSEL && PENABLE && PREADY && PWRITE;
	assign start_cmd = wr_acc && (PADDR == oss_pkg::OFF_CTRL)
		&& PWDATA[oss_pkg::CTRL_START_BIT];
	assign w1c = (wr_acc && PADDR == oss_pkg::OFF_ISTAT)
		? PWDATA[2:0] : 3'h0;

	function automatic logic addr_ok(input logic [7:0] a);
		addr_ok = (a == oss_pkg::OFF_STATUS) || (a == oss_pkg::OFF_CTRL)
			|| (a == oss_pkg::OFF_ISTAT) || (a == oss_pkg::OFF_IMASK);
	endfunction : addr_ok

	function automatic logic [31:0] rd_mux(input logic [7:0] a);
		logic [31:0] v;
		v = 32'h0000_0000;
		case (a)
			oss_pkg::OFF_STATUS:
			begin
				v[oss_pkg::ST_ID_LSB +: oss_pkg::ID_W] = id_r;
				v[oss_pkg::ST_DS_BIT]   = ds_r;
				v[oss_pkg::ST_ME_BIT]   = me_r;
				v[oss_pkg::ST_WP_BIT]   = wp_r;
				v[oss_pkg::ST_PD_BIT]   = pd_r;
				v[oss_pkg::ST_SE_BIT]   = se_r;
				v[oss_pkg::ST_CFG_BIT]  = CONFIG_VALID;
				v[oss_pkg::ST_SPIN_BIT] = SPIN_ENABLE;
				v[oss_pkg::ST_LVD_BIT]  = LVD_MODE;
			end
			oss_pkg::OFF_ISTAT: v[oss_pkg::IRQ_W-1:0] = istat_r;
			oss_pkg::OFF_IMASK: v[oss_pkg::IRQ_W-1:0] = imask_r;
			default:            v = 32'h0000_0000;
		endcase
		rd_mux = v;
	endfunction : rd_mux

	// Zero wait states: ready and data are registered in the setup cycle.
	always_ff @(posedge CLK_SYS or posedge RESET)
	begin
		if (RESET)
		begin
			PREADY  <= 1'b0;
			PRDATA  <= 32'h0000_0000;
			PSLVERR <= 1'b0;
		end
		else
		begin
			PREADY  <= setup;
			PRDATA  <= (setup && !PWRITE) ? rd_mux(PADDR) : 32'h0000_0000;
			PSLVERR <= setup && !addr_ok(PADDR);
		end
	end

	// A new event beats a simultaneous write-one-to-clear.
	always_ff @(posedge CLK_SYS or posedge RESET)
	begin
		if (RESET)
		begin
			imask_r <= oss_pkg::IRQ_RST;
			istat_r <= oss_pkg::IRQ_RST;
			IRQ     <= 1'b0;
		end
		else
		begin
			if (wr_acc && PADDR == oss_pkg::OFF_IMASK)
				imask_r <= PWDATA[oss_pkg::IRQ_W-1:0];
			istat_r <= (istat_r & ~w1c) | irq_evt;
			IRQ     <= |(((istat_r & ~w1c) | irq_evt) & imask_r);
		end
	end

	// ==========================================================
	// Spindle start sequencer
	// ==========================================================
	logic [31:0] step_cnt_r;
	logic [3:0]  id_left_r;
	logic        spin_go;

	always_ff @(posedge CLK_SYS or posedge RESET)
	begin
		if (RESET)
		begin
			state_r    <= oss_pkg::ST_SAMPLE;
			step_cnt_r <= 32'h0000_0000;
			id_left_r  <= 4'h0;
		end
		else
		begin
			case (state_r)
				oss_pkg::ST_SAMPLE:
					if (win_end)
						state_r <= oss_pkg::ST_DECIDE;
				oss_pkg::ST_DECIDE:
				begin
					step_cnt_r <= 32'h0000_0000;
					id_left_r  <= id_r;
					if (me_r) // R3 R5
						state_r <= oss_pkg::ST_WAIT_CMD;
					else if (ds_r && id_r != oss_pkg::ID_ZERO) // R4
						state_r <= oss_pkg::ST_DELAY;
					else // R2
						state_r <= oss_pkg::ST_RUN;
				end
				oss_pkg::ST_DELAY:
					if (step_cnt_r == SPIN_STEP_CYC - 1) // R4
					begin
						step_cnt_r <= 32'h0000_0000;
						id_left_r  <= id_left_r - 4'h1;
						if (id_left_r == 4'h1)
							state_r <= oss_pkg::ST_RUN;
					end
					else
						step_cnt_r <= step_cnt_r + 32'h0000_0001;
				oss_pkg::ST_WAIT_CMD:
					if (start_cmd) // R3 R5
						state_r <= oss_pkg::ST_RUN;
				oss_pkg::ST_RUN:
					state_r <= oss_pkg::ST_RUN;
				default:
					state_r <= oss_pkg::ST_SAMPLE;
			endcase
		end
	end

	assign spin_go = (state_r == oss_pkg::ST_DECIDE && !me_r
			&& (!ds_r || id_r == oss_pkg::ID_ZERO))
		|| (state_r == oss_pkg::ST_DELAY && id_left_r == 4'h1
			&& step_cnt_r == SPIN_STEP_CYC - 1)
		|| (state_r == oss_pkg::ST_WAIT_CMD && start_cmd);

	assign irq_evt = {PARITY_FAIL && !pd_r && CONFIG_VALID,
		spin_go, win_end};

	// ==========================================================
	// Decoded control outputs
	// ==========================================================
	always_ff @(posedge CLK_SYS or posedge RESET)
	begin
		if (RESET)
		begin
			BUS_ID            <= 4'h0;
			ID_TOP_PRIORITY   <= 1'b0;
			CONFIG_VALID      <= 1'b0;
			SPIN_ENABLE       <= 1'b0;
			WRITE_PROTECT     <= 1'b1;
			PARITY_CHECK_EN   <= 1'b0;
			PARITY_ERR_REPORT <= 1'b0;
			LVD_MODE          <= 1'b0;
		end
		else
		begin
			BUS_ID          <= id_r;
			ID_TOP_PRIORITY <= CONFIG_VALID
				&& id_r == oss_pkg::ID_TOP_PRIO; // R13
			CONFIG_VALID    <= CONFIG_VALID || win_end;
			SPIN_ENABLE     <= SPIN_ENABLE || spin_go;
			// Writes stay blocked until the straps are known.
			WRITE_PROTECT   <= !CONFIG_VALID || wp_r; // R6
			PARITY_CHECK_EN <= CONFIG_VALID && !pd_r; // R7 R8
			PARITY_ERR_REPORT <= CONFIG_VALID && !pd_r
				&& PARITY_FAIL; // R7 R8
			LVD_MODE        <= CONFIG_VALID && !se_r
				&& diff_s; // R9 R10
		end
	end

	// ==========================================================
	// Assertions
	// ==========================================================
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (RESET);

	a_id_capture: assert property (win_end |=> id_r == $past(id_s)) // R1
		else $error("identifier not captured at window end");
	a_default_spin: assert property (state_r == oss_pkg::ST_DECIDE
		&& !ds_r && !me_r |=> ##1 SPIN_ENABLE) // R2
		else $error("default straps did not start spindle");
	a_cmd_hold: assert property (state_r == oss_pkg::ST_WAIT_CMD
		&& !start_cmd |=> !SPIN_ENABLE) // R3
		else $error("spindle started without command");
	a_delay_zero: assert property (state_r == oss_pkg::ST_DECIDE
		&& ds_r && !me_r && id_r == oss_pkg::ID_ZERO
		|=> ##1 SPIN_ENABLE) // R4
		else $error("identifier zero start delayed");
	a_delay_wait: assert property (state_r == oss_pkg::ST_DELAY
		&& step_cnt_r != SPIN_STEP_CYC - 1 |=> !SPIN_ENABLE) // R4
		else $error("spindle started before delay ended");
	a_cmd_override: assert property (state_r == oss_pkg::ST_DECIDE
		&& me_r |=> state_r == oss_pkg::ST_WAIT_CMD) // R5
		else $error("delay not overridden by command strap");
	a_write_prot: assert property (CONFIG_VALID && $stable(wp_r)
		|=> WRITE_PROTECT == $past(wp_r)) // R6
		else $error("write protect does not follow strap");
	a_parity_off: assert property (pd_r && CONFIG_VALID
		|=> !PARITY_ERR_REPORT && !PARITY_CHECK_EN) // R7
		else $error("parity reported while disabled");
	a_parity_rep: assert property (CONFIG_VALID && !pd_r && PARITY_FAIL
		|=> PARITY_ERR_REPORT && istat_r[oss_pkg::IRQ_PAR_BIT]) // R8
		else $error("parity failure not reported");
	a_force_se: assert property (CONFIG_VALID && se_r
		|=> !LVD_MODE) // R9
		else $error("differential mode despite forced single-ended");
	a_diffsens: assert property (CONFIG_VALID && !se_r
		|=> LVD_MODE == $past(diff_s)) // R10
		else $error("mode does not follow DIFFSENS");
	a_straps_held: assert property (state_r != oss_pkg::ST_SAMPLE
		|=> $stable(id_r) && $stable(ds_r) && $stable(wp_r)) // R11 R14
		else $error("captured strap changed while powered");
	a_top_prio: assert property (CONFIG_VALID
		|=> ID_TOP_PRIORITY == ($past(id_r) == oss_pkg::ID_TOP_PRIO)) // R13
		else $error("priority flag wrong");

	c_default_start: cover property (state_r == oss_pkg::ST_DECIDE
		&& !ds_r && !me_r);
	c_cmd_start: cover property (state_r == oss_pkg::ST_WAIT_CMD
		&& start_cmd);
	c_delay_start: cover property (state_r == oss_pkg::ST_DELAY
		##1 state_r == oss_pkg::ST_RUN);
	c_parity_irq: cover property (IRQ && istat_r[oss_pkg::IRQ_PAR_BIT]);

endmodule : oss_strap_loader

/* File: shared/oss_pkg.sv */
// Constants shared by the option strap and spindle start block.
package oss_pkg;

	// ==========================================================
	// Timing
	// ==========================================================
	localparam int unsigned CLK_HZ       = 20_000_000;
	localparam int unsigned SAMPLE_MS    = 250;
	localparam int unsigned SAMPLE_CYC   = SAMPLE_MS * (CLK_HZ / 1000);
	localparam int unsigned SPIN_STEP_S  = 12;
	localparam int unsigned SPIN_STEP_CYC = SPIN_STEP_S * CLK_HZ;

	// ==========================================================
	// Identifier
	// ==========================================================
	localparam int          ID_W        = 4;
	localparam logic [3:0]  ID_TOP_PRIO = 4'h7;
	localparam logic [3:0]  ID_ZERO     = 4'h0;
	localparam int          STRAP_W     = 5;

	// ==========================================================
	// Register map (byte addresses)
	// ==========================================================
	localparam logic [7:0] OFF_STATUS = 8'h00;
	localparam logic [7:0] OFF_CTRL   = 8'h04;
	localparam logic [7:0] OFF_ISTAT  = 8'h08;
	localparam logic [7:0] OFF_IMASK  = 8'h0C;

	// STATUS fields.
	localparam int ST_ID_LSB   = 0;
	localparam int ST_DS_BIT   = 4;
	localparam int ST_ME_BIT   = 5;
	localparam int ST_WP_BIT   = 6;
	localparam int ST_PD_BIT   = 7;
	localparam int ST_SE_BIT   = 8;
	localparam int ST_CFG_BIT  = 9;
	localparam int ST_SPIN_BIT = 10;
	localparam int ST_LVD_BIT  = 11;

	// CTRL fields.
	localparam int CTRL_START_BIT = 0;

	// Interrupt status and mask fields.
	localparam int IRQ_W        = 3;
	localparam int IRQ_CFG_BIT  = 0;
	localparam int IRQ_SPIN_BIT = 1;
	localparam int IRQ_PAR_BIT  = 2;
	localparam logic [2:0] IRQ_RST = 3'h0;

	// ==========================================================
	// Sequencer states
	// ==========================================================
	typedef enum logic [2:0] {
		ST_SAMPLE   = 3'b000,
		ST_DECIDE   = 3'b001,
		ST_DELAY    = 3'b010,
		ST_WAIT_CMD = 3'b011,
		ST_RUN      = 3'b100
	} oss_state_e;

endpackage : oss_pkg

/* File: design/oss_sync.sv */
// Two flip-flop synchroniser for a bundle of asynchronous levels.
`timescale 1ns/10ps
module oss_sync #(
	parameter int          W   = 1,
	parameter logic [W-1:0] RST = '0
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// Levels
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_r;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			meta_r <= RST;
			q      <= RST;
		end
		else
		begin
			meta_r <= d;
			q      <= meta_r;
		end
	end

endmodule : oss_sync

/* File: tb/oss_strap_model.sv */
// Jumper plug and host driver model for the strap lines.
`timescale 1ns/10ps
module oss_strap_model (
	// Requested settings
	input  wire logic [3:0] id,
	input  wire logic [4:0] opt,
	// Strap pins, active low
	output logic      [3:0] bus_id_n,
	output logic      [4:0] opt_n
);
	// A fitted jumper or an asserting host pulls its line low.
	assign bus_id_n = ~id;
	assign opt_n    = ~opt;
endmodule : oss_strap_model

/* File: tb/oss_strap_loader_bench.sv */
// Self-checking bench for the option strap loader.
`timescale 1ns/10ps
module oss_strap_loader_bench;
	logic        clk = 1'b0, rst = 1'b1, dfs = 1'b1, pfail = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic [3:0]  id_set = 4'h0, id_n, bus_id;
	logic [4:0]  opt_set = 5'h00, opt_n;
	logic        pready, pslverr, cfg, spin, wp, pce, per, lvd, irq, topp;
	logic [32:0] expq[$];
	int          num_errors = 0;
	int          cmp_count = 0;
	int          seed = 13849;

	initial forever #25 clk = ~clk;

	oss_strap_model model (.id(id_set), .opt(opt_set), .bus_id_n(id_n),
		.opt_n(opt_n));

	oss_strap_loader #(.SAMPLE_CYC(20), .SPIN_STEP_CYC(10)) dut (
		.CLK_SYS(clk), .RESET(rst), .BUS_ID_N(id_n),
		.DELAYED_SPIN_STRAP_N(opt_n[0]), .SPIN_ON_COMMAND_STRAP_N(opt_n[1]),
		.WRITE_PROT_STRAP_N(opt_n[2]), .PARITY_OFF_STRAP_N(opt_n[3]),
		.FORCE_SINGLE_ENDED_STRAP_N(opt_n[4]), .DIFFSENS(dfs),
		.PARITY_FAIL(pfail), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready),
		.PRDATA(prdata), .PSLVERR(pslverr), .BUS_ID(bus_id),
		.ID_TOP_PRIORITY(topp), .CONFIG_VALID(cfg), .SPIN_ENABLE(spin),
		.WRITE_PROTECT(wp), .PARITY_CHECK_EN(pce),
		.PARITY_ERR_REPORT(per), .LVD_MODE(lvd), .IRQ(irq));

	// ==========================================================
	// Shared tasks
	// ==========================================================
	task automatic chk(input logic [32:0] got, input logic [32:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[ERR] %0t saw %h wanted %h", $time, got, exp);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rd(input logic [7:0] a, input logic [32:0] e);
		expq.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask : rd

	// Read answers are matched against the oldest queued note.
	always @(posedge clk)
		if (psel && penable && pready === 1'b1 && !pwrite && expq.size())
			chk({pslverr, prdata}, expq.pop_front());

	// ==========================================================
	// Scenarios
	// ==========================================================
	task automatic run_cfg(input logic [3:0] id, input logic [4:0] opt,
		input logic d);
		int          dly;
		logic [32:0] st;
		dly = (opt[0] && !opt[1]) ? id * 10 : 0;
		st = {21'h0, d && !opt[4], 2'b11, opt, id};
		@(posedge clk);
		id_set <= id;
		opt_set <= opt;
		dfs <= d;
		rst <= 1'b1;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		while (cfg !== 1'b1)
			@(negedge clk);
		// Decoded outputs follow the valid flag by one clock.
		cyc(1);
		chk(33'(bus_id), 33'(id));
		chk(33'(topp), 33'(id == 4'h7));
		chk(33'(wp), 33'(opt[2]));
		chk(33'(pce), 33'(!opt[3]));
		chk(33'(lvd), 33'(d && !opt[4]));
		if (opt[1])
		begin
			cyc(40);
			chk(33'(spin), 33'h0);
			apb(1'b1, oss_pkg::OFF_CTRL, 32'h1);
			cyc(2);
		end
		else
		begin
			if (dly > 0)
			begin
				cyc(dly - 1);
				chk(33'(spin), 33'h0);
			end
			cyc(4);
		end
		chk(33'(spin), 33'h1);
		rd(oss_pkg::OFF_STATUS, st);
		id_set <= ~id;
		opt_set <= ~opt;
		dfs <= ~d;
		cyc(10);
		st[11] = !d && !opt[4];
		rd(oss_pkg::OFF_STATUS, st);
		chk(33'(bus_id), 33'(id));
	endtask : run_cfg

	task automatic irq_test(input logic pd);
		rd(oss_pkg::OFF_ISTAT, 33'h3);
		apb(1'b1, oss_pkg::OFF_IMASK, 32'h7);
		cyc(2);
		chk(33'(irq), 33'h1);
		apb(1'b1, oss_pkg::OFF_ISTAT, 32'h3);
		cyc(2);
		chk(33'(irq), 33'h0);
		@(posedge clk);
		pfail <= 1'b1;
		@(posedge clk);
		pfail <= 1'b0;
		@(negedge clk);
		chk(33'(per), 33'(!pd));
		cyc(2);
		chk(33'(irq), 33'(!pd));
		rd(oss_pkg::OFF_ISTAT, {30'h0, !pd, 2'b00});
		apb(1'b1, oss_pkg::OFF_IMASK, 32'h0);
		cyc(2);
		chk(33'(irq), 33'h0);
		apb(1'b1, oss_pkg::OFF_ISTAT, 32'h4);
		rd(8'h10, {1'b1, 32'h0});
	endtask : irq_test

	task automatic final_report;
		$display("compares %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : final_report

	initial
	begin
		run_cfg(4'($random(seed)), 5'h00, 1'b1);
		irq_test(1'b0);
		$display("test 1 done");
		run_cfg(4'h5, 5'h1E, 1'b1);
		irq_test(1'b1);
		$display("test 2 done");
		run_cfg(4'h2, 5'h01, 1'b0);
		$display("test 3 done");
		run_cfg(4'h7, 5'h03, 1'b1);
		$display("test 4 done");
		run_cfg(4'h0, 5'h01, 1'b1);
		$display("test 5 done");
		final_report();
	end

	// The whole run needs well under a millisecond of simulated time.
	initial
	begin
		#1_000_000;
		num_errors++;
		final_report();
	end
endmodule : oss_strap_loader_bench
